// ===== hw/cbf_exec_core.sv
// Execution core for branch-on-I, bit, flag, shift, move and load operations
`timescale 1ns/1ps
module cbf_exec_core
  import cbf_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Operation request
  input  wire logic        opValid,
  input  wire cbf_op_type  opCode,
  input  wire logic [4:0]  opRd,
  input  wire logic [4:0]  opRr,
  input  wire logic [2:0]  opBit,
  input  wire logic [6:0]  opK,
  input  wire logic [5:0]  opQ,
  input  wire cbf_ptr_type opPtr,
  input  wire logic [4:0]  opIoAddr,
  // Operation status
  output logic             busy,
  output logic             done,
  output logic [15:0]      pcOut,
  output logic [7:0]       statusFlags,
  // Data memory read port
  output logic [15:0]      memAddr,
  output logic             memRead,
  input  wire logic [7:0]  memRdData,
  // I/O register port
  output logic [4:0]       ioAddr,
  output logic             ioRead,
  output logic             ioWrite,
  output logic [7:0]       ioWrData,
  input  wire logic [7:0]  ioRdData,
  // Register file observation
  input  wire logic [4:0]  dbgSel,
  output logic [7:0]       dbgData
);

  typedef enum logic {ST_IDLE, ST_SECOND} cbf_state_type;

  cbf_state_type state_reg;              // Sequencer state
  logic [7:0]    regFile_reg [32];       // Working registers
  logic [7:0]    flags_reg;              // Status flags register
  logic [15:0]   pc_reg;                 // Program counter
  logic          done_reg;               // Completion pulse
  logic [15:0]   memAddr_reg;            // Load address
  logic          memRead_reg;            // Load strobe
  logic [4:0]    ioAddr_reg;             // I/O address
  logic          ioRead_reg;             // I/O read strobe
  logic          ioWrite_reg;            // I/O write strobe
  logic [7:0]    ioWrData_reg;           // I/O write data
  logic [7:0]    dbgData_reg;            // Observed register
  cbf_op_type    heldOp_reg;             // Op held for second cycle
  logic [4:0]    heldRd_reg;             // Destination held
  logic [2:0]    heldBit_reg;            // Bit index held
  logic          accept;                 // Request taken this edge
  logic          branchTaken;            // Branch condition met
  logic [15:0]   ptrNow;                 // Selected pointer value
  logic [4:0]    ptrLo;                  // Low register of pointer
  logic [15:0]   ptrNew;                 // Pointer after update
  logic [15:0]   loadAddr;               // Address for this load

  cbf_shift_if shBus ();

  cbf_shift_unit uShift (
    .sh (shBus.shift)
  );

  // Low register index of a pointer pair
  function automatic logic [4:0] ptrIndex(input cbf_ptr_type p);
    unique case (p)
      PTR_X:   ptrIndex = PTR_X_LO;
      PTR_Y:   ptrIndex = PTR_Y_LO;
      default: ptrIndex = PTR_Z_LO;  // Code 3 is illegal, treated as Z
    endcase
  endfunction : ptrIndex

  // Shift unit operands
  assign shBus.kind    = opCode;
  assign shBus.operand = regFile_reg[opRd];
  assign shBus.carryIn = flags_reg[FLAG_C];

  // Only one request in flight; a two-cycle op blocks the next
  assign accept = opValid && (state_reg == ST_IDLE);

  assign branchTaken =
    (opCode == OP_BRANCH_IF_IRQ_ENABLED  &&  flags_reg[FLAG_I]) ||
    (opCode == OP_BRANCH_IF_IRQ_DISABLED && !flags_reg[FLAG_I]);

  // Pointer arithmetic for indirect loads
  assign ptrLo  = ptrIndex(opPtr);
  assign ptrNow = {regFile_reg[ptrLo + 5'd1], regFile_reg[ptrLo]};
  always_comb begin
    ptrNew   = ptrNow;
    loadAddr = ptrNow;
    unique case (opCode)
      OP_LOAD_POST_INC: ptrNew = ptrNow + 16'h0001;
      OP_LOAD_PRE_DEC: begin
        ptrNew   = ptrNow - 16'h0001;
        loadAddr = ptrNew;
      end
      OP_LOAD_WITH_DISPLACEMENT:
        loadAddr = ptrNow + {10'h000, opQ};
      default: ptrNew = ptrNow;
    endcase
  end

  // Sequencer: two-cycle ops spend one extra cycle in ST_SECOND
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else if (state_reg == ST_SECOND) begin
      state_reg <= ST_IDLE;
    end else if (accept) begin
      unique case (opCode)
        OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
        OP_LOAD, OP_LOAD_POST_INC, OP_LOAD_PRE_DEC,
        OP_LOAD_WITH_DISPLACEMENT:
          state_reg <= ST_SECOND;
        OP_BRANCH_IF_IRQ_ENABLED, OP_BRANCH_IF_IRQ_DISABLED:
          state_reg <= branchTaken ? ST_SECOND : ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Fields kept for the second cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      heldOp_reg  <= OP_NOP;
      heldRd_reg  <= 5'h00;
      heldBit_reg <= 3'h0;
    end else if (accept) begin
      heldOp_reg  <= opCode;
      heldRd_reg  <= opRd;
      heldBit_reg <= opBit;
    end
  end

  // Program counter: next word, or relative target on a taken branch
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pc_reg <= PC_RESET;
    end else if (accept) begin
      if (branchTaken) begin
        pc_reg <= pc_reg + {{9{opK[6]}}, opK} + 16'h0001;
      end else begin
        pc_reg <= pc_reg + 16'h0001;
      end
    end
  end

  // Status flags; all other ops leave them alone
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags_reg <= STATUS_RESET;
    end else if (accept) begin
      unique case (opCode)
        OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
        OP_ARITH_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY: begin
          flags_reg[FLAG_C] <= shBus.carryOut;
          flags_reg[FLAG_Z] <= shBus.zeroOut;
          flags_reg[FLAG_N] <= shBus.negOut;
          flags_reg[FLAG_V] <= shBus.ovfOut;
        end
        OP_STATUS_FLAG_SET:   flags_reg[opBit] <= 1'b1;
        OP_STATUS_FLAG_CLEAR: flags_reg[opBit] <= 1'b0;
        OP_REG_BIT_TO_T_FLAG:
          flags_reg[FLAG_T] <= regFile_reg[opRr][opBit];
        default: flags_reg <= flags_reg;
      endcase
    end
  end

  // Working registers; loaded byte wins over a pointer write to it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) begin
        regFile_reg[i] <= REG_RESET;
      end
    end else if (state_reg == ST_SECOND) begin
      if (memRead_reg) begin
        regFile_reg[heldRd_reg] <= memRdData;
      end
    end else if (accept) begin
      unique case (opCode)
        OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
        OP_ARITH_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY:
          regFile_reg[opRd] <= shBus.result;
        OP_NIBBLE_SWAP:
          regFile_reg[opRd] <= {regFile_reg[opRd][3:0],
                                regFile_reg[opRd][7:4]};
        OP_T_FLAG_TO_REG_BIT:
          regFile_reg[opRd][opBit] <= flags_reg[FLAG_T];
        OP_MOVE:
          regFile_reg[opRd] <= regFile_reg[opRr];
        OP_REGISTER_PAIR_COPY: begin
          // Pair indices are even; bit 0 is forced low
          regFile_reg[{opRd[4:1], 1'b0}] <= regFile_reg[{opRr[4:1], 1'b0}];
          regFile_reg[{opRd[4:1], 1'b1}] <= regFile_reg[{opRr[4:1], 1'b1}];
        end
        OP_LOAD_POST_INC, OP_LOAD_PRE_DEC: begin
          regFile_reg[ptrLo]         <= ptrNew[7:0];
          regFile_reg[ptrLo + 5'd1]  <= ptrNew[15:8];
        end
        default: regFile_reg[opRd] <= regFile_reg[opRd];
      endcase
    end
  end

  // Data memory strobe: address out in the cycle after acceptance
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      memAddr_reg <= 16'h0000;
      memRead_reg <= 1'b0;
    end else begin
      memRead_reg <= accept && (opCode == OP_LOAD ||
                                opCode == OP_LOAD_POST_INC ||
                                opCode == OP_LOAD_PRE_DEC ||
                                opCode == OP_LOAD_WITH_DISPLACEMENT);
      if (accept) begin
        memAddr_reg <= loadAddr;
      end
    end
  end

  // I/O read-modify-write; write strobe lands with the done pulse
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ioAddr_reg   <= 5'h00;
      ioRead_reg   <= 1'b0;
      ioWrite_reg  <= 1'b0;
      ioWrData_reg <= 8'h00;
    end else begin
      ioRead_reg  <= accept && (opCode == OP_IO_BIT_SET ||
                                opCode == OP_IO_BIT_CLEAR);
      ioWrite_reg <= ioRead_reg;
      if (accept) begin
        ioAddr_reg <= opIoAddr;
      end
      if (ioRead_reg) begin
        ioWrData_reg <= ioRdData;
        if (heldOp_reg == OP_IO_BIT_SET) begin
          ioWrData_reg[heldBit_reg] <= 1'b1;
        end else begin
          ioWrData_reg[heldBit_reg] <= 1'b0;
        end
      end
    end
  end

  // Completion pulse after the last cycle of each op
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == ST_SECOND) ||
                  (accept && !((opCode == OP_IO_BIT_SET) ||
                               (opCode == OP_IO_BIT_CLEAR) ||
                               (opCode == OP_LOAD) ||
                               (opCode == OP_LOAD_POST_INC) ||
                               (opCode == OP_LOAD_PRE_DEC) ||
                               (opCode == OP_LOAD_WITH_DISPLACEMENT) ||
                               branchTaken));
    end
  end

  // Register observation port, one cycle behind the select
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dbgData_reg <= REG_RESET;
    end else begin
      dbgData_reg <= regFile_reg[dbgSel];
    end
  end

  // Outputs straight from flip-flops
  assign busy        = (state_reg == ST_SECOND);
  assign done        = done_reg;
  assign pcOut       = pc_reg;
  assign statusFlags = flags_reg;
  assign memAddr     = memAddr_reg;
  assign memRead     = memRead_reg;
  assign ioAddr      = ioAddr_reg;
  assign ioRead      = ioRead_reg;
  assign ioWrite     = ioWrite_reg;
  assign ioWrData    = ioWrData_reg;
  assign dbgData     = dbgData_reg;

endmodule : cbf_exec_core

// ===== hw/cbf_pkg.sv
// Shared constants and types for the bit, flag and load execution core
package cbf_pkg;

  // Status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Pointer pair low-byte register indices
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  // Reset values
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [7:0]  REG_RESET    = 8'h00;

  // Cycle counts per class of operation
  localparam int CYCLES_SINGLE = 1;
  localparam int CYCLES_DOUBLE = 2;

  // Operations the core executes
  typedef enum logic [4:0] {
    OP_NOP,
    OP_BRANCH_IF_IRQ_ENABLED,
    OP_BRANCH_IF_IRQ_DISABLED,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_LOGICAL_LEFT_SHIFT,
    OP_LOGICAL_RIGHT_SHIFT,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_RIGHT_SHIFT,
    OP_NIBBLE_SWAP,
    OP_STATUS_FLAG_SET,
    OP_STATUS_FLAG_CLEAR,
    OP_REG_BIT_TO_T_FLAG,
    OP_T_FLAG_TO_REG_BIT,
    OP_MOVE,
    OP_REGISTER_PAIR_COPY,
    OP_LOAD,
    OP_LOAD_POST_INC,
    OP_LOAD_PRE_DEC,
    OP_LOAD_WITH_DISPLACEMENT
  } cbf_op_type;

  // Pointer selection for indirect loads
  typedef enum logic [1:0] {
    PTR_X,
    PTR_Y,
    PTR_Z
  } cbf_ptr_type;

endpackage : cbf_pkg

// ===== hw/cbf_shift_if.sv
// Carrier between the execution core and its shift unit
`timescale 1ns/1ps
interface cbf_shift_if;
  import cbf_pkg::*;
  cbf_op_type  kind;      // Which shift or rotate
  logic [7:0]  operand;   // Source byte
  logic        carryIn;   // Current carry flag
  logic [7:0]  result;    // Shifted byte
  logic        carryOut;  // New carry
  logic        zeroOut;   // New zero flag
  logic        negOut;    // New negative flag
  logic        ovfOut;    // New overflow flag

  modport core  (output kind, operand, carryIn,
                 input  result, carryOut, zeroOut, negOut, ovfOut);
  modport shift (input  kind, operand, carryIn,
                 output result, carryOut, zeroOut, negOut, ovfOut);
endinterface : cbf_shift_if

// ===== hw/cbf_shift_unit.sv
// Combinational shift and rotate unit with flag results
`timescale 1ns/1ps
module cbf_shift_unit
  import cbf_pkg::*;
(
  cbf_shift_if.shift sh
);

  // Result and carry per kind
  always_comb begin
    sh.result   = sh.operand;
    sh.carryOut = sh.carryIn;
    unique case (sh.kind)
      OP_LOGICAL_LEFT_SHIFT: begin
        sh.result   = {sh.operand[6:0], 1'b0};
        sh.carryOut = sh.operand[7];
      end
      OP_LOGICAL_RIGHT_SHIFT: begin
        sh.result   = {1'b0, sh.operand[7:1]};
        sh.carryOut = sh.operand[0];
      end
      OP_ARITH_RIGHT_SHIFT: begin
        sh.result   = {sh.operand[7], sh.operand[7:1]};
        sh.carryOut = sh.operand[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        sh.result   = {sh.operand[6:0], sh.carryIn};
        sh.carryOut = sh.operand[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        sh.result   = {sh.carryIn, sh.operand[7:1]};
        sh.carryOut = sh.operand[0];
      end
      default: begin
        // Other kinds never reach the flag update; pass through
        sh.result   = sh.operand;
        sh.carryOut = sh.carryIn;
      end
    endcase
  end

  // Flags derived from the shifted byte; V follows N xor C
  assign sh.zeroOut = (sh.result == 8'h00);
  assign sh.negOut  = sh.result[7];
  assign sh.ovfOut  = sh.result[7] ^ sh.carryOut;

endmodule : cbf_shift_unit

// ===== test/cbf_exec_properties.sv
// Port-level checker for the execution core
`timescale 1ns/1ps
module cbf_exec_props
  import cbf_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // Request
  input wire logic        opValid,
  input wire cbf_op_type  opCode,
  input wire logic [2:0]  opBit,
  input wire logic [6:0]  opK,
  // Status
  input wire logic        busy,
  input wire logic        done,
  input wire logic [15:0] pcOut,
  input wire logic [7:0]  statusFlags,
  // Memory and I/O
  input wire logic        memRead,
  input wire logic        ioRead,
  input wire logic        ioWrite,
  input wire logic [4:0]  ioAddr,
  input wire logic [7:0]  ioWrData,
  input wire logic [7:0]  ioRdData
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Request taken at this edge
  logic        acc;
  // Shift or rotate request
  logic        isShift;
  // Offset widened to the counter width
  logic [15:0] kExt;
  assign acc = opValid && !busy;
  assign isShift = opCode inside {OP_LOGICAL_LEFT_SHIFT,
    OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_RIGHT_SHIFT};
  assign kExt = {{9{opK[6]}}, opK};

  a_load_two_cycle: assert property (
    memRead |-> busy ##1 (done && !busy))
    else $error("load not finished in two cycles");
  a_io_set_bit: assert property (
    acc && opCode == OP_IO_BIT_SET ##1 ioRead |=> ioWrite && done &&
    $stable(ioAddr) &&
    ioWrData == ($past(ioRdData) | (8'h01 << $past(opBit, 2))))
    else $error("bit set write back wrong");
  a_io_clear_bit: assert property (
    acc && opCode == OP_IO_BIT_CLEAR ##1 ioRead |=> ioWrite && done &&
    ioWrData == ($past(ioRdData) & ~(8'h01 << $past(opBit, 2))))
    else $error("bit clear write back wrong");
  a_io_one_bit: assert property (
    ioRead ##1 ioWrite |-> $countones(ioWrData ^ $past(ioRdData)) <= 1)
    else $error("bit op changed more than one bit");
  a_shift_one_cycle: assert property (
    acc && isShift |=> done && !busy && pcOut == $past(pcOut) + 16'h0001)
    else $error("shift not done in one cycle");
  a_shift_flag_link: assert property (
    acc && isShift |=> statusFlags[FLAG_V] ==
    (statusFlags[FLAG_N] ^ statusFlags[FLAG_C]) &&
    statusFlags[FLAG_S] == $past(statusFlags[FLAG_S]))
    else $error("shift flags inconsistent");
  a_branch_taken: assert property (
    acc && opCode == OP_BRANCH_IF_IRQ_DISABLED && !statusFlags[FLAG_I] |=>
    busy && pcOut == $past(pcOut) + $past(kExt) + 16'h0001
    ##1 done && $stable(statusFlags))
    else $error("taken branch wrong");
  a_branch_skip: assert property (
    acc && opCode == OP_BRANCH_IF_IRQ_ENABLED && !statusFlags[FLAG_I] |=>
    done && !busy && pcOut == $past(pcOut) + 16'h0001)
    else $error("untaken branch wrong");
  a_flag_set_only: assert property (
    acc && opCode == OP_STATUS_FLAG_SET |=>
    statusFlags == ($past(statusFlags) | (8'h01 << $past(opBit))))
    else $error("flag set touched other bits");
  a_swap_no_flags: assert property (
    acc && opCode inside {OP_NIBBLE_SWAP, OP_MOVE, OP_REGISTER_PAIR_COPY}
    |=> done && $stable(statusFlags))
    else $error("flags moved on swap or move");

  // Main scenarios reached
  c_pre_dec: cover property (acc && opCode == OP_LOAD_PRE_DEC);
  c_io_write: cover property (ioWrite);
  c_shift: cover property (acc && isShift);
endmodule : cbf_exec_props

bind cbf_exec_core cbf_exec_props cbf_exec_props_inst (.mclk(mclk),
  .resetn(resetn), .opValid(opValid), .opCode(opCode), .opBit(opBit),
  .opK(opK), .busy(busy), .done(done), .pcOut(pcOut),
  .statusFlags(statusFlags), .memRead(memRead), .ioRead(ioRead),
  .ioWrite(ioWrite), .ioAddr(ioAddr), .ioWrData(ioWrData),
  .ioRdData(ioRdData));

// ===== test/testbench.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
module testbench;
  import cbf_pkg::*;
  // Design inputs
  logic        mclk, resetn, opValid;
  cbf_op_type  opCode;
  logic [4:0]  opRd, opRr, opIoAddr, dbgSel;
  logic [2:0]  opBit;
  logic [6:0]  opK;
  logic [5:0]  opQ;
  cbf_ptr_type opPtr;
  logic [7:0]  memRdData, ioRdData;
  // Design outputs
  logic        busy, done, memRead, ioRead, ioWrite;
  logic [15:0] pcOut, memAddr;
  logic [7:0]  statusFlags, ioWrData, dbgData;
  logic [4:0]  ioAddr;
  // Bench state
  int          err_count, num_checks;
  logic [15:0] pcE, seenAddr;
  logic [7:0]  seenWr, sfE;
  logic [4:0]  seenIo;

  cbf_exec_core cbf_exec_core_inst (.mclk(mclk), .resetn(resetn),
    .opValid(opValid), .opCode(opCode), .opRd(opRd), .opRr(opRr),
    .opBit(opBit), .opK(opK), .opQ(opQ), .opPtr(opPtr),
    .opIoAddr(opIoAddr), .busy(busy), .done(done), .pcOut(pcOut),
    .statusFlags(statusFlags), .memAddr(memAddr), .memRead(memRead),
    .memRdData(memRdData), .ioAddr(ioAddr), .ioRead(ioRead),
    .ioWrite(ioWrite), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .dbgSel(dbgSel), .dbgData(dbgData));

  // Memory answers at once; contents follow the address
  assign memRdData = memAddr[7:0] ^ 8'ha5;

  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Compare and count
  task automatic check(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  // Issue one request, wait for done, check length and counter
  task automatic op(cbf_op_type c, logic [4:0] rd, logic [4:0] rr,
    logic [2:0] b, cbf_ptr_type p, logic [6:0] k, logic [5:0] q,
    int n, logic [15:0] dpc);
    int cyc;
    @(posedge mclk);
    opValid <= 1'b1;
    opCode <= c;
    opRd <= rd;
    opRr <= rr;
    opBit <= b;
    opPtr <= p;
    opK <= k;
    opQ <= q;
    @(posedge mclk);
    opValid <= 1'b0;
    cyc = 0;
    // Bounded wait; strobes are sampled in their own cycle
    do begin
      #1;
      cyc++;
      if (memRead === 1'b1) seenAddr = memAddr;
      if (ioRead === 1'b1) seenIo = ioAddr;
      if (ioWrite === 1'b1) seenWr = ioWrData;
      if (done !== 1'b1) @(posedge mclk);
    end while (done !== 1'b1 && cyc < 5);
    pcE = pcE + dpc;
    check(16'(cyc), 16'(n));
    check(pcOut, pcE);
  endtask : op

  // Read one register through the observation port
  task automatic reg_is(logic [4:0] i, logic [7:0] e);
    @(posedge mclk);
    dbgSel <= i;
    @(posedge mclk);
    #1;
    check(dbgData, e);
  endtask : reg_is

  // Pointer updates and addresses of every load form
  task automatic t_loads();
    op(OP_LOAD_POST_INC, 2, 0, 0, PTR_X, 0, 0, 2, 1);
    check(seenAddr, 16'h0000);
    reg_is(2, 8'ha5);
    reg_is(26, 8'h01);
    op(OP_LOAD, 1, 0, 0, PTR_X, 0, 0, 2, 1);
    check(seenAddr, 16'h0001);
    reg_is(1, 8'ha4);
    reg_is(26, 8'h01);
    op(OP_LOAD_PRE_DEC, 5, 0, 0, PTR_X, 0, 0, 2, 1);
    check(seenAddr, 16'h0000);
    reg_is(26, 8'h00);
    op(OP_LOAD_WITH_DISPLACEMENT, 3, 0, 0, PTR_Y, 0, 6'h25, 2, 1);
    check(seenAddr, 16'h0025);
    reg_is(3, 8'h80);
    reg_is(28, 8'h00);
    check(statusFlags, 8'h00);
  endtask : t_loads

  // Every flag index set, then cleared, one at a time
  task automatic t_flags();
    sfE = 8'h00;
    for (int i = 0; i < 8; i++) begin
      op(OP_STATUS_FLAG_SET, 0, 0, 3'(i), PTR_X, 0, 0, 1, 1);
      sfE[i] = 1'b1;
      check(statusFlags, sfE);
    end
    for (int i = 0; i < 8; i++) begin
      op(OP_STATUS_FLAG_CLEAR, 0, 0, 3'(i), PTR_X, 0, 0, 1, 1);
      sfE[i] = 1'b0;
      check(statusFlags, sfE);
    end
  endtask : t_flags

  // Each shift on a fresh copy; carry chains from one to the next
  task automatic t_shifts();
    cbf_op_type sOp [5];
    logic [7:0] sRes [5];
    logic [7:0] sFl [5];
    sOp = '{OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
      OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT};
    sRes = '{8'h4a, 8'h52, 8'h4b, 8'hd2, 8'hd2};
    sFl = '{8'h19, 8'h19, 8'h19, 8'h15, 8'h15};
    // S held high shows shifts leave it alone
    op(OP_STATUS_FLAG_SET, 0, 0, 4, PTR_X, 0, 0, 1, 1);
    for (int i = 0; i < 5; i++) begin
      op(OP_LOAD, 1, 0, 0, PTR_Z, 0, 0, 2, 1);
      op(sOp[i], 1, 0, 0, PTR_X, 0, 0, 1, 1);
      reg_is(1, sRes[i]);
      check(statusFlags, sFl[i]);
    end
    op(OP_LOGICAL_LEFT_SHIFT, 3, 0, 0, PTR_X, 0, 0, 1, 1);
    reg_is(3, 8'h00);
    check(statusFlags, 8'h1b);
  endtask : t_shifts

  // Swap, T transfers and moves
  task automatic t_misc();
    op(OP_LOAD, 1, 0, 0, PTR_Z, 0, 0, 2, 1);
    op(OP_NIBBLE_SWAP, 1, 0, 0, PTR_X, 0, 0, 1, 1);
    reg_is(1, 8'h5a);
    check(statusFlags, 8'h1b);
    op(OP_REG_BIT_TO_T_FLAG, 0, 1, 1, PTR_X, 0, 0, 1, 1);
    check(statusFlags, 8'h5b);
    op(OP_T_FLAG_TO_REG_BIT, 3, 0, 7, PTR_X, 0, 0, 1, 1);
    reg_is(3, 8'h80);
    op(OP_MOVE, 4, 1, 0, PTR_X, 0, 0, 1, 1);
    reg_is(4, 8'h5a);
    op(OP_REGISTER_PAIR_COPY, 6, 0, 0, PTR_X, 0, 0, 1, 1);
    reg_is(6, 8'h00);
    reg_is(7, 8'h5a);
    check(statusFlags, 8'h5b);
  endtask : t_misc

  // Both branches with I clear, then with I set
  task automatic t_branch();
    op(OP_BRANCH_IF_IRQ_ENABLED, 0, 0, 0, PTR_X, 5, 0, 1, 1);
    op(OP_BRANCH_IF_IRQ_DISABLED, 0, 0, 0, PTR_X, 7'h7d, 0, 2,
      16'hfffe);
    op(OP_STATUS_FLAG_SET, 0, 0, 7, PTR_X, 0, 0, 1, 1);
    op(OP_BRANCH_IF_IRQ_ENABLED, 0, 0, 0, PTR_X, 4, 0, 2, 5);
    op(OP_BRANCH_IF_IRQ_DISABLED, 0, 0, 0, PTR_X, 4, 0, 1, 1);
    check(statusFlags, 8'hdb);
  endtask : t_branch

  // Read-modify-write of one I/O bit
  task automatic t_io();
    @(posedge mclk);
    ioRdData <= 8'h5a;
    op(OP_IO_BIT_SET, 0, 0, 0, PTR_X, 0, 0, 2, 1);
    check(seenIo, 5'h11);
    check(seenWr, 8'h5b);
    op(OP_IO_BIT_CLEAR, 0, 0, 1, PTR_X, 0, 0, 2, 1);
    check(seenWr, 8'h58);
    check(statusFlags, 8'hdb);
  endtask : t_io

  // Verdict and end of run
  task automatic conclude();
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // Hang guard, well beyond the expected run
  initial begin
    #200us;
    err_count++;
    conclude();
  end

  // Main sequence
  initial begin
    {resetn, opValid, opRd, opRr, opBit, opK, opQ, dbgSel} = '0;
    opCode = OP_NOP;
    opPtr = PTR_X;
    opIoAddr = 5'h11;
    ioRdData = 8'h00;
    pcE = 16'h0000;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    t_loads();
    t_flags();
    t_shifts();
    t_misc();
    t_branch();
    t_io();
    conclude();
  end
endmodule : testbench
